// *** verilog/doc_consts.vh ***
`ifndef DOC_CONSTS_VH
`define DOC_CONSTS_VH

// Register byte offsets
`define DOC_OFF_MODE      8'h00
`define DOC_OFF_PORT      8'h04
`define DOC_OFF_LINE      8'h08
`define DOC_OFF_PREC      8'h0c
`define DOC_OFF_INTERVAL  8'h10
`define DOC_OFF_BAUD      8'h14
`define DOC_OFF_STATUS    8'h18
`define DOC_OFF_FRAMES    8'h1c

// Mode values that let display data out
`define DOC_MODE_DISP_A   4'h1
`define DOC_MODE_DISP_B   4'h3

// Port select encodings
`define DOC_PORT_RS485    1'b0
`define DOC_PORT_RS232    1'b1

// Reset values
`define DOC_RST_MODE      4'h0
`define DOC_RST_PORT      1'b0
`define DOC_RST_LINE      4'h0
`define DOC_RST_PREC      4'h3
`define DOC_RST_INTERVAL  16'h000a
`define DOC_RST_BAUD      32'h00002580

// Host-side advisory limits
`define DOC_MIN_INTERVAL  16'h000a
`define DOC_MAX_BAUD      32'h00009600

// Status field positions
`define DOC_ST_PORT       4
`define DOC_ST_INT_LOW    16
`define DOC_ST_BAUD_HIGH  17

// Bus responses
`define DOC_RESP_OKAY     2'b00
`define DOC_RESP_SLVERR   2'b10

`endif

// *** verilog/doc_display_cfg.v ***
`timescale 1ns/1ps
`include "doc_consts.vh"

module doc_display_cfg #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              frame_req,
  output reg               send_rs485_q,
  output reg               send_rs232_q,
  output reg  [3:0]        frame_line_q,
  output reg  [3:0]        frame_prec_q,
  output reg  [15:0]       frame_interval_q
);

  //////////////////////////////////////////////////////////////////////////
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = (a[ADDR_W-1:5] == {(ADDR_W-5){1'b0}});
    end
  endfunction

  function [7:0] word_off;
    input [ADDR_W-1:0] a;
    begin
      word_off = {3'b000, a[4:2], 2'b00};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  reg  [3:0]        output_mode_select_q;
  reg               port_sel_q;
  reg  [3:0]        display_line_select_q;
  reg  [3:0]        display_precision_q;
  reg  [15:0]       output_interval_q;
  reg  [31:0]       serial_baud_setting_q;
  reg  [3:0]        act_mode_q;
  reg               act_port_q;
  reg  [31:0]       frames_q;
  reg               aw_hold_q;
  reg               w_hold_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [31:0]       wdata_q;
  reg  [3:0]        wstrb_q;
  wire              do_write;
  wire              mode_ok;
  wire              int_low;
  wire              baud_high;
  wire [31:0]       status;
  reg  [31:0]       rd_mux;
  wire [31:0]       mode_mrg;
  wire [31:0]       intv_mrg;

  assign do_write  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign mode_mrg  = merge({28'h0000000, output_mode_select_q},
                           wdata_q, wstrb_q);
  assign intv_mrg  = merge({16'h0000, output_interval_q}, wdata_q, wstrb_q);
  assign mode_ok   = (output_mode_select_q == `DOC_MODE_DISP_A) ||
                     (output_mode_select_q == `DOC_MODE_DISP_B);
  // Advisory only: the host owns these limits, hardware just reports
  assign int_low   = output_interval_q < `DOC_MIN_INTERVAL;
  assign baud_high = serial_baud_setting_q > `DOC_MAX_BAUD;
  assign status    = {14'h0000, baud_high, int_low,
                      frame_prec_q, frame_line_q,
                      3'h0, act_port_q, act_mode_q};

  //////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready         <= 1'b1;
      s_axi_wready          <= 1'b1;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= `DOC_RESP_OKAY;
      aw_hold_q             <= 1'b0;
      w_hold_q              <= 1'b0;
      awaddr_q              <= {ADDR_W{1'b0}};
      wdata_q               <= 32'h00000000;
      wstrb_q               <= 4'h0;
      output_mode_select_q  <= `DOC_RST_MODE;
      port_sel_q            <= `DOC_RST_PORT;
      display_line_select_q <= `DOC_RST_LINE;
      display_precision_q   <= `DOC_RST_PREC;
      output_interval_q     <= `DOC_RST_INTERVAL;
      serial_baud_setting_q <= `DOC_RST_BAUD;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_q) ? `DOC_RESP_OKAY : `DOC_RESP_SLVERR;
        // Upper address bits alias low offsets, so unmapped writes must drop
        if (mapped(awaddr_q)) begin
          case (word_off(awaddr_q))
            `DOC_OFF_MODE:
              output_mode_select_q <= mode_mrg[3:0];
            `DOC_OFF_PORT:
              port_sel_q <= wstrb_q[0] ? wdata_q[0] : port_sel_q;
            `DOC_OFF_LINE:
              display_line_select_q <= wstrb_q[0] ? wdata_q[3:0]
                                                  : display_line_select_q;
            `DOC_OFF_PREC:
              display_precision_q <= wstrb_q[0] ? wdata_q[3:0]
                                                : display_precision_q;
            `DOC_OFF_INTERVAL:
              output_interval_q <= intv_mrg[15:0];
            `DOC_OFF_BAUD:
              serial_baud_setting_q <= merge(serial_baud_setting_q,
                                             wdata_q, wstrb_q);
            default: ;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always @* begin
    case (word_off(s_axi_araddr))
      `DOC_OFF_MODE:     rd_mux = {28'h0000000, output_mode_select_q};
      `DOC_OFF_PORT:     rd_mux = {31'h00000000, port_sel_q};
      `DOC_OFF_LINE:     rd_mux = {28'h0000000, display_line_select_q};
      `DOC_OFF_PREC:     rd_mux = {28'h0000000, display_precision_q};
      `DOC_OFF_INTERVAL: rd_mux = {16'h0000, output_interval_q};
      `DOC_OFF_BAUD:     rd_mux = serial_baud_setting_q;
      `DOC_OFF_STATUS:   rd_mux = status;
      `DOC_OFF_FRAMES:   rd_mux = frames_q;
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DOC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= mapped(s_axi_araddr) ? rd_mux : 32'h00000000;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `DOC_RESP_OKAY
                                            : `DOC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Settings snapshot once per frame so no frame mixes old and new values
  always @(posedge aclk) begin
    if (!aresetn) begin
      send_rs485_q     <= 1'b0;
      send_rs232_q     <= 1'b0;
      frame_line_q     <= `DOC_RST_LINE;
      frame_prec_q     <= `DOC_RST_PREC;
      frame_interval_q <= `DOC_RST_INTERVAL;
      act_mode_q       <= `DOC_RST_MODE;
      act_port_q       <= `DOC_RST_PORT;
      frames_q         <= 32'h00000000;
    end else begin
      send_rs485_q <= 1'b0;
      send_rs232_q <= 1'b0;
      if (frame_req) begin
        act_mode_q       <= output_mode_select_q;
        act_port_q       <= port_sel_q;
        frame_line_q     <= display_line_select_q;
        frame_prec_q     <= display_precision_q;
        frame_interval_q <= output_interval_q;
        if (mode_ok) begin
          send_rs485_q <= (port_sel_q == `DOC_PORT_RS485);
          send_rs232_q <= (port_sel_q == `DOC_PORT_RS232);
          frames_q     <= frames_q + 32'h00000001;
        end
      end
    end
  end

endmodule // doc_display_cfg

// *** verif/doc_cfg_props.sv ***
`timescale 1ns/1ps
module doc_cfg_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        frame_req,
  input wire        send_rs485_q,
  input wire        send_rs232_q,
  input wire [3:0]  frame_line_q,
  input wire [3:0]  frame_prec_q,
  input wire [15:0] frame_interval_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_send_cause:
    assert property ((send_rs485_q || send_rs232_q) |-> $past(frame_req))
      else $error("send pulse without frame request");
  chk_one_port:
    assert property (!(send_rs485_q && send_rs232_q))
      else $error("frame sent on both ports");
  chk_line_hold:
    assert property (!$past(frame_req) |-> $stable(frame_line_q))
      else $error("line selection changed between frames");
  chk_prec_hold:
    assert property (!$past(frame_req) |-> $stable(frame_prec_q))
      else $error("precision changed between frames");
  chk_interval_hold:
    assert property (!$past(frame_req) |-> $stable(frame_interval_q))
      else $error("interval changed between frames");
endmodule // doc_cfg_props

bind doc_display_cfg doc_cfg_props u_props (
  .aclk(aclk), .aresetn(aresetn), .frame_req(frame_req),
  .send_rs485_q(send_rs485_q), .send_rs232_q(send_rs232_q),
  .frame_line_q(frame_line_q), .frame_prec_q(frame_prec_q),
  .frame_interval_q(frame_interval_q));

// *** verif/doc_display_model.sv ***
`timescale 1ns/1ps
module doc_display_model (
  input wire aclk,
  input wire send_rs485_q,
  input wire send_rs232_q,
  output int rx485_cnt,
  output int rx232_cnt
);
  // No rate setting: the unit follows whatever the instrument sends
  int n485 = 0;
  int n232 = 0;
  assign rx485_cnt = n485;
  assign rx232_cnt = n232;
  always @(posedge aclk) begin
    if (send_rs485_q) n485 <= n485 + 1;
    if (send_rs232_q) n232 <= n232 + 1;
  end
endmodule // doc_display_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic aclk = 0, aresetn = 0, frame_req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, bd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, send_rs485_q, send_rs232_q, p;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
  logic [3:0] frame_line_q, frame_prec_q, m, l, pr, pl = 0;
  logic [15:0] frame_interval_q, iv;
  int fail_count = 0, tests_run = 0, e485 = 0, e232 = 0, c485, c232;
  always #4 aclk = ~aclk;
  doc_display_cfg dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .frame_req, .send_rs485_q, .send_rs232_q,
    .frame_line_q, .frame_prec_q, .frame_interval_q);
  doc_display_model u_disp (.aclk, .send_rs485_q, .send_rs232_q,
    .rx485_cnt(c485), .rx232_cnt(c232));
  //////////////////////////////////////////////////////////////////////////
  function logic en(input logic [3:0] mv);
    return mv == 4'h1 || mv == 4'h3;
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Response channels always ready, so each write ends on its bvalid edge
  task wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    b = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task fr(input int n);
    frame_req <= 1;
    repeat (n) @(posedge aclk);
    frame_req <= 0;
    @(posedge aclk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h05f5));
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(8'h0c);
    chk("prec_reset", d, 32'h3);
    rd(8'h10);
    chk("interval_reset", d, 32'ha);
    rd(8'h20);
    chk("unmapped_resp", r, 2'b10);
    // Every mode value, with random port, line and precision
    for (int i = 0; i < 16; i++) begin
      m = i;
      p = $urandom % 2;
      l = $urandom % 16;
      pr = $urandom % 16;
      wr(8'h00, {28'h0, m});
      wr(8'h04, {31'h0, p});
      wr(8'h08, {28'h0, l});
      wr(8'h0c, {28'h0, pr});
      chk("line_before_frame", frame_line_q, pl);
      fr(1);
      chk("rs485", send_rs485_q, en(m) & ~p);
      chk("rs232", send_rs232_q, en(m) & p);
      chk("line", frame_line_q, l);
      chk("prec", frame_prec_q, pr);
      if (en(m)) begin
        if (p) e232++;
        else e485++;
      end
      pl = l;
    end
    iv = 16'($urandom % 200) + 16'h000a;
    bd = $urandom % 32'h00009601;
    wr(8'h10, {16'h0000, iv});
    wr(8'h14, bd);
    chk("wr_okay", b, 2'b00);
    rd(8'h14);
    chk("baud", d, bd);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h0);
    // Aliases the port offset; must be refused and leave the port alone
    wr(8'h24, 32'h1);
    chk("unmapped_wr", b, 2'b10);
    rd(8'h04);
    chk("port_kept", d, 32'h0);
    fr(2);
    e485 += 2;
    chk("interval", frame_interval_q, iv);
    @(posedge aclk);
    chk("count485", c485, e485);
    chk("count232", c232, e232);
    rd(8'h1c);
    chk("frames", d, e485 + e232);
    rd(8'h18);
    chk("status", d, {14'h0, 2'b00, pr, l, 3'h0, 1'b0, 4'h3});
    print_verdict;
  end
endmodule // tb
